//--- common/mcel_pkg.sv
// Constants shared by the error status logger and its counter.
package mcel_pkg;
    // Register byte offsets on the bus.
    localparam logic [7:0] OFS_STAT_LO = 8'h00;
    localparam logic [7:0] OFS_STAT_HI = 8'h04;
    localparam logic [7:0] OFS_IRQ_ST = 8'h08;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h0c;
    localparam logic [7:0] OFS_CTRL = 8'h10;
    // Status field positions.
    localparam int BIT_BUS_APAR = 16;
    localparam int BIT_BUS_RFAIL = 17;
    localparam int BIT_BUS_RPAR = 18;
    localparam int BIT_BUS_DPAR = 19;
    localparam int BIT_BUS_INV = 20;
    localparam int BIT_PAD_SYNC = 21;
    localparam int BIT_PAD_DSTB = 22;
    localparam int BIT_PAD_ASTB = 23;
    localparam int BIT_MEM_TAG = 16;
    localparam int BIT_MEM_DATA = 18;
    localparam int BIT_MEM_L3 = 20;
    localparam int BIT_MEM_INV = 21;
    localparam int BIT_CNT = 32;
    // Fixed parts of the compound error codes.
    localparam logic [4:0] BUS_CODE_TOP = 5'h01;
    localparam logic [7:0] MEM_CODE_TOP = 8'h01;
    // Interrupt status bits.
    localparam int IRQ_BUS = 0;
    localparam int IRQ_MEM = 1;
    localparam int IRQ_LOST = 2;
    // Values after reset and limits.
    localparam logic [63:0] STAT_RST = 64'h0;
    localparam logic [2:0] IRQ_RST = 3'h0;
    localparam logic [7:0] CNT_RST = 8'h00;
    localparam logic [7:0] CNT_MAX = 8'hff;
    localparam logic [31:0] RDATA_RST = 32'h0;
endpackage : mcel_pkg

//--- src/mcel_err_counter.sv
// Saturating count of machine check errors after the first since reset.
`timescale 1ns/1ns
module mcel_err_counter
    import mcel_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic inc,
    output logic [7:0] count,
    output logic [7:0] count_nxt
);
    typedef struct packed {
        logic seen;
        logic [7:0] cnt;
    } mcel_cnt_t;

    mcel_cnt_t s_r;
    mcel_cnt_t s_nxt;

    always_comb begin
        s_nxt = s_r;
        if (inc) begin
            if (!s_r.seen) begin
                s_nxt.seen = 1'b1;
            end else if (s_r.cnt != CNT_MAX) begin
                s_nxt.cnt = s_r.cnt + 8'h01;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_r <= '{seen: 1'b0, cnt: CNT_RST};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign count = s_r.cnt;
    // The logger snapshots the value that includes the error of this cycle.
    assign count_nxt = s_nxt.cnt;
endmodule : mcel_err_counter

//--- src/mcel_logger.sv
// Machine check error status logger with an AHB-Lite register slave.
//
// Chosen here: the AHB-Lite register port and the address map.
`timescale 1ns/1ns
module mcel_logger
    import mcel_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic bus_err_valid,
    input wire logic [1:0] bus_pp,
    input wire logic bus_t,
    input wire logic [3:0] bus_rrrr,
    input wire logic [1:0] bus_ii,
    input wire logic [1:0] bus_ll,
    input wire logic bus_addr_par,
    input wire logic bus_resp_fail,
    input wire logic bus_resp_par,
    input wire logic bus_data_par,
    input wire logic bus_inv_req,
    input wire logic pad_sync_err,
    input wire logic pad_strobe_glitch,
    input wire logic pad_addr_glitch,
    input wire logic mem_err_valid,
    input wire logic [3:0] mem_rrrr,
    input wire logic [1:0] mem_tt,
    input wire logic [1:0] mem_ll,
    input wire logic [1:0] mem_tag_code,
    input wire logic [1:0] mem_data_code,
    input wire logic mem_l3,
    input wire logic mem_inv_req,
    output logic irq
);
    import mcel_pkg::*;

    typedef struct packed {
        logic wr_pend;
        logic [7:0] wr_addr;
        logic [31:0] rdata;
        logic [63:0] stat;
        logic logged;
        logic [2:0] irq_st;
        logic [2:0] mask;
        logic rev_sel;
    } mcel_state_t;

    mcel_state_t s_r;
    mcel_state_t s_nxt;
    logic [7:0] cnt;
    logic [7:0] cnt_log;
    logic take;
    logic clr;
    logic free;
    logic any_err;

    // A register is hit only when every upper address bit is zero.
    function automatic logic is_reg(input logic [31:0] a, input logic [7:0] ofs);
        is_reg = (a[31:8] == 24'h0) && (a[7:0] == ofs);
    endfunction : is_reg

    assign any_err = bus_err_valid || mem_err_valid;

    mcel_err_counter u_cnt (
        .hclk(hclk),
        .hresetn(hresetn),
        .inc(any_err),
        .count(cnt),
        .count_nxt(cnt_log)
    );

    // ****************************************************************
    // Next state
    // ****************************************************************
    assign take = hsel && hready && htrans[1];
    assign clr = s_r.wr_pend && (s_r.wr_addr == OFS_STAT_LO || s_r.wr_addr == OFS_STAT_HI);
    // A new error in the clearing cycle is logged, so set wins over clear.
    assign free = !s_r.logged || clr;

    always_comb begin
        s_nxt = s_r;
        s_nxt.wr_pend = take && hwrite;
        s_nxt.wr_addr = (haddr[31:8] == 24'h0) ? haddr[7:0] : 8'hff;
        if (clr) begin
            s_nxt.stat = STAT_RST;
            s_nxt.logged = 1'b0;
        end
        if (s_r.wr_pend) begin
            if (s_r.wr_addr == OFS_IRQ_ST) begin
                s_nxt.irq_st = s_r.irq_st & ~hwdata[2:0];
            end else if (s_r.wr_addr == OFS_IRQ_MASK) begin
                s_nxt.mask = hwdata[2:0];
            end else if (s_r.wr_addr == OFS_CTRL) begin
                s_nxt.rev_sel = hwdata[0];
            end
        end
        if (bus_err_valid && free) begin
            s_nxt.stat = STAT_RST;
            s_nxt.stat[15:0] = {4'h0, BUS_CODE_TOP[0], bus_pp, bus_t, bus_rrrr, bus_ii, bus_ll};
            s_nxt.stat[BIT_BUS_APAR] = bus_addr_par;
            s_nxt.stat[BIT_BUS_RFAIL] = bus_resp_fail;
            s_nxt.stat[BIT_BUS_RPAR] = bus_resp_par;
            s_nxt.stat[BIT_BUS_DPAR] = bus_data_par;
            s_nxt.stat[BIT_BUS_INV] = bus_inv_req && s_r.rev_sel;
            s_nxt.stat[BIT_PAD_SYNC] = pad_sync_err;
            s_nxt.stat[BIT_PAD_DSTB] = pad_strobe_glitch;
            s_nxt.stat[BIT_PAD_ASTB] = pad_addr_glitch;
            s_nxt.logged = 1'b1;
            s_nxt.irq_st[IRQ_BUS] = 1'b1;
        end else if (mem_err_valid && free) begin
            s_nxt.stat = STAT_RST;
            s_nxt.stat[15:0] = {MEM_CODE_TOP, mem_rrrr, mem_tt, mem_ll};
            s_nxt.stat[BIT_MEM_TAG +: 2] = mem_tag_code;
            s_nxt.stat[BIT_MEM_DATA +: 2] = mem_data_code;
            s_nxt.stat[BIT_MEM_L3] = mem_l3;
            s_nxt.stat[BIT_MEM_INV] = mem_inv_req;
            s_nxt.stat[BIT_CNT +: 8] = cnt_log;
            s_nxt.logged = 1'b1;
            s_nxt.irq_st[IRQ_MEM] = 1'b1;
        end
        // Errors that find the snapshot held are counted but not logged.
        if (any_err && !free) begin
            s_nxt.irq_st[IRQ_LOST] = 1'b1;
        end
        if (bus_err_valid && mem_err_valid && free) begin
            s_nxt.irq_st[IRQ_LOST] = 1'b1;
        end
        // Read data is taken from the updated image so a read after a write sees it.
        if (take && !hwrite) begin
            if (is_reg(haddr, OFS_STAT_LO)) begin
                s_nxt.rdata = s_nxt.stat[31:0];
            end else if (is_reg(haddr, OFS_STAT_HI)) begin
                s_nxt.rdata = s_nxt.stat[63:32];
            end else if (is_reg(haddr, OFS_IRQ_ST)) begin
                s_nxt.rdata = {29'h0, s_nxt.irq_st};
            end else if (is_reg(haddr, OFS_IRQ_MASK)) begin
                s_nxt.rdata = {29'h0, s_nxt.mask};
            end else if (is_reg(haddr, OFS_CTRL)) begin
                s_nxt.rdata = {31'h0, s_nxt.rev_sel};
            end else begin
                s_nxt.rdata = RDATA_RST;
            end
        end
    end

    // ****************************************************************
    // State register and outputs
    // ****************************************************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_r <= '{wr_pend: 1'b0, wr_addr: 8'h00, rdata: RDATA_RST, stat: STAT_RST,
                     logged: 1'b0, irq_st: IRQ_RST, mask: IRQ_RST, rev_sel: 1'b0};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = s_r.rdata;
    assign irq = |(s_r.irq_st & s_r.mask);

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    sequence bus_take_s;
        bus_err_valid && free;
    endsequence

    sequence mem_take_s;
        !bus_err_valid && mem_err_valid && free;
    endsequence

    bus_code_a: assert property (bus_take_s |=> s_r.stat[15:0] ==
        {5'h01, $past(bus_pp), $past(bus_t), $past(bus_rrrr), $past(bus_ii), $past(bus_ll)})
        else $error("bus error code not logged");
    bus_apar_a: assert property (bus_take_s |=> s_r.stat[16] == $past(bus_addr_par))
        else $error("address parity bit wrong");
    bus_rfail_a: assert property (bus_take_s |=> s_r.stat[17] == $past(bus_resp_fail))
        else $error("response fail bit wrong");
    bus_rpar_a: assert property (bus_take_s |=> s_r.stat[18] == $past(bus_resp_par))
        else $error("response parity bit wrong");
    bus_dpar_a: assert property (bus_take_s |=> s_r.stat[19] == $past(bus_data_par))
        else $error("data parity bit wrong");
    bus_inv_a: assert property (bus_take_s ##0 !s_r.rev_sel |=> !s_r.stat[20])
        else $error("request flag set on other revision");
    pad_flags_a: assert property (bus_take_s |=> s_r.stat[23:21] ==
        {$past(pad_addr_glitch), $past(pad_strobe_glitch), $past(pad_sync_err)})
        else $error("pad flags wrong");
    mem_code_a: assert property (mem_take_s |=> s_r.stat[15:0] ==
        {8'h01, $past(mem_rrrr), $past(mem_tt), $past(mem_ll)})
        else $error("memory error code not logged");
    mem_tag_a: assert property (mem_take_s |=> s_r.stat[17:16] == $past(mem_tag_code))
        else $error("tag code wrong");
    mem_data_a: assert property (mem_take_s |=> s_r.stat[19:18] == $past(mem_data_code))
        else $error("data code wrong");
    mem_lvl_a: assert property (mem_take_s |=> s_r.stat[21:20] ==
        {$past(mem_inv_req), $past(mem_l3)})
        else $error("level or request bit wrong");
    cnt_first_a: assert property ($rose(u_cnt.s_r.seen) |-> cnt == 8'h00 && $past(cnt) == 8'h00)
        else $error("first error not counted as zero");
    cnt_step_a: assert property (any_err && u_cnt.s_r.seen |=> cnt ==
        (($past(cnt) == 8'hff) ? 8'hff : $past(cnt) + 8'h01))
        else $error("count step wrong");
    resv_zero_a: assert property (s_r.logged && s_r.stat[11] |-> s_r.stat[63:24] == 40'h0)
        else $error("bus reserved bits not zero");
    resv_mem_a: assert property (s_r.logged && !s_r.stat[11] |->
        s_r.stat[31:22] == 10'h0 && s_r.stat[63:40] == 24'h0)
        else $error("memory reserved bits not zero");
    hold_snap_a: assert property (s_r.logged && !clr |=> $stable(s_r.stat))
        else $error("snapshot changed while held");

    // ****************************************************************
    // Register bus, counter and snapshot checks
    // ****************************************************************
    sequence rd_lo_s;
        take && !hwrite && is_reg(haddr, OFS_STAT_LO);
    endsequence

    sequence rd_hi_s;
        take && !hwrite && is_reg(haddr, OFS_STAT_HI);
    endsequence

    sequence rd_unmapped_s;
        take && !hwrite && haddr[31:8] != 24'h0;
    endsequence

    sequence held_hit_s;
        s_r.logged && !clr && any_err;
    endsequence

    bus_inv_on_a: assert property (bus_take_s ##0 s_r.rev_sel |=> s_r.stat[20] == $past(bus_inv_req))
        else $error("request flag lost on selected revision");
    mem_inv_a: assert property (mem_take_s |=> s_r.stat[21] == $past(mem_inv_req))
        else $error("write back request bit wrong");
    // The snapshot must carry the count that includes its own error.
    mem_cnt_a: assert property (mem_take_s |=> s_r.stat[39:32] == cnt)
        else $error("count snapshot wrong");
    cnt_sat_a: assert property (cnt == 8'hff |=> cnt == 8'hff)
        else $error("count left saturation");
    cnt_idle_a: assert property (!any_err |=> $stable(cnt))
        else $error("count moved without an error");
    clr_stat_a: assert property (clr && !any_err |=> s_r.stat == STAT_RST && !s_r.logged)
        else $error("status write did not clear");
    // An error that finds the snapshot held must leave a trace, or software never learns it was lost.
    held_lost_a: assert property (held_hit_s |=> s_r.irq_st[IRQ_LOST] && $stable(s_r.stat))
        else $error("error while held not flagged as lost");
    bus_wins_a: assert property (bus_err_valid && mem_err_valid && free |=>
        s_r.stat[11] && s_r.irq_st[IRQ_LOST])
        else $error("bus error did not win");
    bus_irq_a: assert property (bus_take_s |=> s_r.logged && s_r.irq_st[IRQ_BUS])
        else $error("bus error not held");
    mem_irq_a: assert property (mem_take_s |=> s_r.logged && s_r.irq_st[IRQ_MEM])
        else $error("memory error not held");
    // A handler reads the two words in separate transfers, so each must show the image of its own cycle.
    rd_lo_a: assert property (rd_lo_s |=> hrdata == s_r.stat[31:0])
        else $error("low status word read wrong");
    rd_hi_a: assert property (rd_hi_s |=> hrdata == s_r.stat[63:32])
        else $error("high status word read wrong");
    rd_unmapped_a: assert property (rd_unmapped_s |=> hrdata == RDATA_RST)
        else $error("unmapped read not zero");
    // Read data must stand through the data phase, whatever else the bus does.
    rd_hold_a: assert property (!(take && !hwrite) |=> $stable(hrdata))
        else $error("read data changed without a read");
    wr_ignore_a: assert property (s_r.wr_pend && s_r.wr_addr == 8'hff |=>
        $stable(s_r.mask) && $stable(s_r.rev_sel))
        else $error("unmapped write changed a register");
    mask_wr_a: assert property (s_r.wr_pend && s_r.wr_addr == OFS_IRQ_MASK |=>
        s_r.mask == $past(hwdata[2:0]))
        else $error("mask write lost");
    irq_w1c_a: assert property (s_r.wr_pend && s_r.wr_addr == OFS_IRQ_ST && !any_err |=>
        (s_r.irq_st & $past(hwdata[2:0])) == 3'h0)
        else $error("written one did not clear");
endmodule : mcel_logger

//--- testbench/mcel_logger_bench.sv
// Self-checking bench for the machine check error status logger.
`timescale 1ns/1ns
module mcel_logger_bench;
    import mcel_pkg::*;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [1:0] htrans = 2'b00;
    logic [2:0] hsize = 3'b010;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic [31:0] r;
    logic [31:0] e;
    logic [31:0] rnd;
    logic hreadyout;
    logic hresp;
    logic hready;
    logic irq;
    logic bv = 1'b0;
    logic mv = 1'b0;
    logic [18:0] bf = 19'h0;
    logic [13:0] mf = 14'h0;
    int fails = 0;
    int n_compared = 0;
    int nerr = 0;
    int seed = 1072;

    assign hready = hreadyout;
    always #10 hclk = ~hclk;

    mcel_logger dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .bus_err_valid(bv), .bus_pp(bf[10:9]), .bus_t(bf[8]),
        .bus_rrrr(bf[7:4]), .bus_ii(bf[3:2]), .bus_ll(bf[1:0]), .bus_addr_par(bf[11]),
        .bus_resp_fail(bf[12]), .bus_resp_par(bf[13]), .bus_data_par(bf[14]), .bus_inv_req(bf[15]),
        .pad_sync_err(bf[16]), .pad_strobe_glitch(bf[17]), .pad_addr_glitch(bf[18]),
        .mem_err_valid(mv), .mem_rrrr(mf[7:4]), .mem_tt(mf[3:2]), .mem_ll(mf[1:0]),
        .mem_tag_code(mf[9:8]), .mem_data_code(mf[11:10]), .mem_l3(mf[12]), .mem_inv_req(mf[13]),
        .irq(irq));

    // ****************************************
    // Bus, error and check tasks
    // ****************************************
    task automatic chk(input logic [31:0] s, input logic [31:0] x);
        n_compared++;
        if (s !== x) begin
            fails++;
            $display("MISMATCH %0t got %h expected %h", $time, s, x);
        end
    endtask : chk

    // The whole address phase is held until hready is seen high.
    task automatic xfer(input bit wr, input logic [8:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {23'h0, a};
        hwrite <= wr;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        q = hrdata;
    endtask : xfer

    task automatic pulse(input bit b, input bit m, input logic [7:0] fo, input logic [3:0] dt);
        @(posedge hclk);
        rnd = $random(seed);
        bf <= rnd[18:0] | {fo, 11'h0};
        mf <= {rnd[31:30], dt, rnd[29:22]};
        bv <= b;
        mv <= m;
        @(posedge hclk);
        bv <= 1'b0;
        mv <= 1'b0;
        nerr++;
    endtask : pulse

    function automatic logic [31:0] ecnt();
        return (nerr > 256) ? 32'h0000_00ff : 32'(nerr - 1);
    endfunction : ecnt

    task automatic finish_test;
        if (fails == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : finish_test

    // ****************************************
    // Scenarios
    // ****************************************
    initial begin
        repeat (5000) @(posedge hclk);
        fails++;
        finish_test();
    end

    initial begin
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            xfer(1'b0, (i == 5) ? 9'h100 : 9'(i * 4), 32'h0, r);
            chk(r, 32'h0); // reset and unmapped
        end
        xfer(1'b1, 9'h100, 32'hffff_ffff, r);
        xfer(1'b0, 9'h100, 32'h0, r);
        chk(r, 32'h0); // unmapped write
        chk({30'h0, hreadyout, hresp}, 32'h2); // unmapped access answers OKAY
        xfer(1'b1, {1'b0, OFS_IRQ_MASK}, 32'h0, r);
        for (int v = 0; v < 4; v++) begin
            xfer(1'b1, {1'b0, OFS_CTRL}, 32'(v & 1), r);
            xfer(1'b1, {1'b0, OFS_STAT_LO}, 32'h0, r);
            pulse(1'b1, 1'b0, (v > 1) ? 8'hff : 8'h00, 4'h0);
            xfer(1'b0, {1'b0, OFS_STAT_LO}, 32'h0, r);
            chk(r, {8'h0, bf[18:16], bf[15] & v[0], bf[14:11], 5'h01, bf[10:0]});
            xfer(1'b0, {1'b0, OFS_STAT_HI}, 32'h0, r);
            chk(r, 32'h0); // bus upper word
        end
        e = {8'h0, bf[18:16], bf[15], bf[14:11], 5'h01, bf[10:0]};
        xfer(1'b0, {1'b0, OFS_CTRL}, 32'h0, r);
        chk(r, 32'h1); // revision select kept
        // Interrupt: masked first, then enabled, then cleared by writing one.
        @(negedge hclk);
        chk({31'h0, irq}, 32'h0);
        xfer(1'b1, {1'b0, OFS_IRQ_MASK}, 32'hffff_fff9, r);
        xfer(1'b0, {1'b0, OFS_IRQ_MASK}, 32'h0, r);
        chk(r, 32'h1); // mask upper bits ignored
        @(negedge hclk);
        chk({31'h0, irq}, 32'h1);
        xfer(1'b1, {1'b0, OFS_IRQ_ST}, 32'h1, r);
        @(negedge hclk);
        chk({31'h0, irq}, 32'h0);
        xfer(1'b0, {1'b0, OFS_STAT_LO}, 32'h0, r);
        chk(r, e); // kept after irq clear
        for (int i = 0; i < 4; i++) begin
            xfer(1'b1, {1'b0, OFS_STAT_HI}, 32'h0, r);
            pulse(1'b0, 1'b1, 8'h00, {i[1:0], i[1:0]});
            xfer(1'b0, {1'b0, OFS_STAT_LO}, 32'h0, r);
            chk(r, {10'h0, mf[13:8], 8'h01, mf[7:0]});
            xfer(1'b0, {1'b0, OFS_STAT_HI}, 32'h0, r);
            chk(r, ecnt()); // count
        end
        e = {10'h0, mf[13:8], 8'h01, mf[7:0]};
        pulse(1'b1, 1'b0, 8'h00, 4'h0);
        xfer(1'b0, {1'b0, OFS_STAT_LO}, 32'h0, r);
        chk(r, e); // held snapshot
        xfer(1'b0, {1'b0, OFS_IRQ_ST}, 32'h0, r);
        chk(r, 32'h6);
        xfer(1'b1, {1'b0, OFS_IRQ_ST}, 32'h7, r);
        xfer(1'b1, {1'b0, OFS_STAT_LO}, 32'h0, r);
        xfer(1'b0, {1'b0, OFS_STAT_LO}, 32'h0, r);
        chk(r, 32'h0); // cleared by software
        pulse(1'b1, 1'b1, 8'h00, 4'h0);
        xfer(1'b0, {1'b0, OFS_STAT_LO}, 32'h0, r);
        chk(r, {8'h0, bf[18:11], 5'h01, bf[10:0]}); // bus wins
        xfer(1'b0, {1'b0, OFS_IRQ_ST}, 32'h0, r);
        chk(r, 32'h5);
        // Saturation: counting goes on while a snapshot is held.
        repeat (260) pulse(1'b0, 1'b1, 8'h00, 4'h0);
        xfer(1'b1, {1'b0, OFS_STAT_LO}, 32'h0, r);
        pulse(1'b0, 1'b1, 8'h00, 4'h0);
        xfer(1'b0, {1'b0, OFS_STAT_HI}, 32'h0, r);
        chk(r, 32'h0000_00ff); // saturates
        finish_test();
    end
endmodule : mcel_logger_bench
